// >>> rtl/acq_sample_convert_timing.sv
`timescale 1ns/1ps
`default_nettype none
module acq_sample_convert_timing
  import acq_timing_pkg::*;
#(
  parameter int DIV_W = 16,
  parameter int CNT_W = 24,
  parameter int CH_W  = 8
) (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        TIMEBASE_100M,
  input  wire logic        TIMEBASE_20M,
  input  wire logic        TIMEBASE_100K,
  input  wire logic        BACKPLANE_10MHZ_CLOCK,
  input  wire logic [15:0] FUNC_LINES_IN,
  input  wire logic [7:0]  TRIG_BUS_IN,
  input  wire logic        STAR_IN,
  input  wire logic [1:0]  DIFF_STAR_IN,
  input  wire logic        ANALOG_COMPARE_EVENT,
  input  wire logic        COUNTER_OUTPUT,
  input  wire logic        CHANGE_DETECT_EVENT,
  input  wire logic [1:0]  OTHER_SCAN_PULSE,
  input  wire logic        START_TRIGGER,
  input  wire logic        PAUSE_TRIGGER,
  output logic      [15:0] FUNC_LINES_OUT,
  output logic      [15:0] FUNC_LINES_OE_N,
  output logic      [7:0]  TRIG_BUS_OUT,
  output logic      [7:0]  TRIG_BUS_OE_N,
  output logic             STAR_OUT,
  output logic             STAR_OE_N,
  output logic             CONVERT_START,
  output logic      [7:0]  CONVERT_CHANNEL,
  output logic             SCAN_START,
  output logic             ACQ_ACTIVE,
  output logic             SCAN_OVERRUN
);

  function automatic logic edge_of(input logic prev, input logic cur, input logic falling);
    edge_of = falling ? (prev & ~cur) : (~prev & cur);
  endfunction
  function automatic logic pick_line(input logic [31:0] lines, input logic [5:0] code);
    pick_line = code[5] ? 1'b0 : lines[code[4:0]];
  endfunction
  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] din,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = din[8*i +: 8];
      end
    end
    merge_sel = res;
  endfunction
  logic [CTRL_W-1:0]  ctrl;
  logic [5:0]         scan_src;
  logic [5:0]         conv_src;
  logic [5:0]         tb_src;
  logic [DIV_W-1:0]   scan_div;
  logic [DIV_W-1:0]   conv_div;
  logic [DIV_W-1:0]   start_dly;
  logic [DIV_W-1:0]   conv_dly;
  logic [CNT_W-1:0]   samples;
  logic [CH_W-1:0]    channels;
  logic [ROUTE_W-1:0] route_en;
  logic [ROUTE_W-1:0] route_sel;
  acq_state_t         state;
  logic [CNT_W-1:0]   remain;
  logic [DIV_W-1:0]   scan_cnt;
  logic [DIV_W-1:0]   conv_cnt;
  logic [CH_W-1:0]    conv_left;
  logic [CH_W-1:0]    chan_idx;
  logic               overrun;
  logic [31:0]        lines;
  logic [31:0]        lines_prev;
  logic               tb_level;
  logic               tb_prev;
  logic               tb100_prev;
  logic               start_prev;
  logic               wb_req;
  logic               wb_wr;
  logic [31:0]        rd_data;
  logic               sw_start;
  logic               sw_stop;
  logic               sw_scan;
  logic               tb_fall;
  logic               scan_tb_tick;
  logic               conv_tb_tick;
  logic               acq_on;
  logic               paused;
  logic               finite_done;
  logic               int_scan_fire;
  logic               scan_event;
  logic               accept_scan;
  logic               conv_event;
  logic               accept_conv;
  logic               acq_done;
  logic               start_req;
  logic [ROUTE_W-1:0] route_val;
  assign lines = {OTHER_SCAN_PULSE, CHANGE_DETECT_EVENT, COUNTER_OUTPUT, ANALOG_COMPARE_EVENT,
                  DIFF_STAR_IN, STAR_IN, TRIG_BUS_IN, FUNC_LINES_IN};
  // Register bus: one wait state, so every access is acked in the cycle after the request
  assign wb_req   = WB_CYC_I & WB_STB_I;
  assign wb_wr    = wb_req & WB_WE_I & WB_ACK_O;
  assign sw_start = wb_wr && WB_ADR_I == OFS_CMD && WB_SEL_I[0] && WB_DAT_I[CMD_START];
  assign sw_stop  = wb_wr && WB_ADR_I == OFS_CMD && WB_SEL_I[0] && WB_DAT_I[CMD_STOP];
  assign sw_scan  = wb_wr && WB_ADR_I == OFS_CMD && WB_SEL_I[0] && WB_DAT_I[CMD_SW_SCAN];
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_req & ~WB_ACK_O;
      if (wb_req & ~WB_ACK_O) begin
        WB_DAT_O <= WB_WE_I ? 32'h0000_0000 : rd_data;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    if (WB_ADR_I == OFS_CTRL) begin
      rd_data[CTRL_W-1:0] = ctrl;
    end else if (WB_ADR_I == OFS_STATUS) begin
      rd_data[STS_ACTIVE]  = acq_on;
      rd_data[STS_OVERRUN] = overrun;
      rd_data[STS_IN_SCAN] = conv_left != '0;
    end else if (WB_ADR_I == OFS_SOURCE) begin
      rd_data[SRC_SCAN_POS +: 6] = scan_src;
      rd_data[SRC_CONV_POS +: 6] = conv_src;
      rd_data[SRC_TB_POS +: 6]   = tb_src;
    end else if (WB_ADR_I == OFS_SCAN_DIV) begin
      rd_data[DIV_W-1:0] = scan_div;
    end else if (WB_ADR_I == OFS_CONV_DIV) begin
      rd_data[DIV_W-1:0] = conv_div;
    end else if (WB_ADR_I == OFS_START_DLY) begin
      rd_data[DIV_W-1:0] = start_dly;
    end else if (WB_ADR_I == OFS_CONV_DLY) begin
      rd_data[DIV_W-1:0] = conv_dly;
    end else if (WB_ADR_I == OFS_SAMPLES) begin
      rd_data[CNT_W-1:0] = samples;
    end else if (WB_ADR_I == OFS_CHANNELS) begin
      rd_data[CH_W-1:0] = channels;
    end else if (WB_ADR_I == OFS_ROUTE_EN) begin
      rd_data[ROUTE_W-1:0] = route_en;
    end else if (WB_ADR_I == OFS_ROUTE_SEL) begin
      rd_data[ROUTE_W-1:0] = route_sel;
    end else if (WB_ADR_I == OFS_REMAIN) begin
      rd_data[CNT_W-1:0] = remain;
    end
  end
  // Configuration registers; writes land at the edge where ack is seen high
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl      <= '0;
      scan_src  <= RST_SCAN_SRC;
      conv_src  <= RST_CONV_SRC;
      tb_src    <= RST_TB_SRC;
      scan_div  <= RST_DIV;
      conv_div  <= RST_DIV;
      start_dly <= RST_START_DLY; // (R10)
      conv_dly  <= RST_CONV_DLY; // (R19)
      samples   <= '0;
      channels  <= RST_CHANNELS;
      route_en  <= '0; // (R6)
      route_sel <= '0;
    end else if (wb_wr) begin
      if (WB_ADR_I == OFS_CTRL) begin
        ctrl <= CTRL_W'(merge_sel(32'(ctrl), WB_DAT_I, WB_SEL_I)); // (R2) (R15) (R13)
      end else if (WB_ADR_I == OFS_SOURCE) begin
        if (WB_SEL_I[0]) scan_src <= WB_DAT_I[SRC_SCAN_POS +: 6]; // (R3)
        if (WB_SEL_I[1]) conv_src <= WB_DAT_I[SRC_CONV_POS +: 6]; // (R16)
        if (WB_SEL_I[2]) tb_src <= WB_DAT_I[SRC_TB_POS +: 6]; // (R12)
      end else if (WB_ADR_I == OFS_SCAN_DIV) begin
        scan_div <= DIV_W'(merge_sel(32'(scan_div), WB_DAT_I, WB_SEL_I)); // (R4)
      end else if (WB_ADR_I == OFS_CONV_DIV) begin
        conv_div <= DIV_W'(merge_sel(32'(conv_div), WB_DAT_I, WB_SEL_I)); // (R17)
      end else if (WB_ADR_I == OFS_START_DLY) begin
        start_dly <= DIV_W'(merge_sel(32'(start_dly), WB_DAT_I, WB_SEL_I)); // (R10)
      end else if (WB_ADR_I == OFS_CONV_DLY) begin
        conv_dly <= DIV_W'(merge_sel(32'(conv_dly), WB_DAT_I, WB_SEL_I)); // (R19)
      end else if (WB_ADR_I == OFS_SAMPLES) begin
        samples <= CNT_W'(merge_sel(32'(samples), WB_DAT_I, WB_SEL_I));
      end else if (WB_ADR_I == OFS_CHANNELS) begin
        channels <= CH_W'(merge_sel(32'(channels), WB_DAT_I, WB_SEL_I)); // (R25)
      end else if (WB_ADR_I == OFS_ROUTE_EN) begin
        route_en <= ROUTE_W'(merge_sel(32'(route_en), WB_DAT_I, WB_SEL_I)); // (R6)
      end else if (WB_ADR_I == OFS_ROUTE_SEL) begin
        route_sel <= ROUTE_W'(merge_sel(32'(route_sel), WB_DAT_I, WB_SEL_I));
      end
    end
  end
  // Timebase selection and edge detection
  always_comb begin
    tb_level = pick_line(lines, tb_src);
    if (tb_src == TB_100M) tb_level = TIMEBASE_100M;
    else if (tb_src == TB_20M) tb_level = TIMEBASE_20M;
    else if (tb_src == TB_100K) tb_level = TIMEBASE_100K;
    else if (tb_src == TB_CLK10) tb_level = BACKPLANE_10MHZ_CLOCK;
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      lines_prev <= '0;
      tb_prev    <= 1'b0;
      tb100_prev <= 1'b0;
      start_prev <= 1'b0;
    end else begin
      lines_prev <= lines;
      tb_prev    <= tb_level;
      tb100_prev <= TIMEBASE_100M;
      start_prev <= START_TRIGGER;
    end
  end
  // Fast internal timebases always count on the rising edge
  assign tb_fall      = ctrl[CTRL_TB_FALL] && tb_src != TB_100M && tb_src != TB_20M; // (R13)
  assign scan_tb_tick = edge_of(tb_prev, tb_level, tb_fall);
  assign conv_tb_tick = ctrl[CTRL_CONV_TB100] ? edge_of(tb100_prev, TIMEBASE_100M, 1'b0)
                                              : scan_tb_tick; // (R24)
  assign acq_on      = state != ST_IDLE;
  assign paused      = PAUSE_TRIGGER ^ ctrl[CTRL_PAUSE_LOW];
  assign finite_done = !ctrl[CTRL_CONTINUOUS] && remain == '0;
  assign start_req   = edge_of(start_prev, START_TRIGGER, 1'b0) | sw_start;
  // Internal scan divider halts while paused
  assign int_scan_fire = acq_on && !paused && !finite_done && scan_src == SRC_DIVIDED &&
                         scan_tb_tick && scan_cnt <= DIV_W'(1); // (R4)
  always_comb begin
    if (scan_src == SRC_DIVIDED) scan_event = int_scan_fire;
    else if (scan_src == SRC_SOFTWARE) scan_event = sw_scan;
    else scan_event = edge_of(pick_line(lines_prev, scan_src), pick_line(lines, scan_src),
                              ctrl[CTRL_SCAN_FALL]); // (R2) (R3)
  end
  // The timing source of an external scan is not checked; an early pulse shows as overrun
  assign accept_scan = acq_on && !paused && !finite_done && scan_event; // (R7) (R8) (R20) (R11)
  always_comb begin
    if (conv_src == SRC_DIVIDED) conv_event = conv_tb_tick && conv_cnt <= DIV_W'(1); // (R17)
    else conv_event = edge_of(pick_line(lines_prev, conv_src), pick_line(lines, conv_src),
                              ctrl[CTRL_CONV_FALL]); // (R15) (R16)
  end
  assign accept_conv = acq_on && conv_left != '0 && conv_event && !accept_scan; // (R21) (R20)
  assign acq_done    = state == ST_RUN && finite_done && conv_left == '0;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          // Retrigger is refused while a run is in progress
          if (start_req) state <= (scan_src == SRC_DIVIDED) ? ST_DELAY : ST_RUN; // (R9)
        end
        ST_DELAY: begin
          if (sw_stop || finite_done) state <= ST_IDLE; // (R9)
          else if (int_scan_fire) state <= ST_RUN;
        end
        ST_RUN: begin
          if (sw_stop || acq_done) state <= ST_IDLE; // (R9)
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      scan_cnt <= RST_START_DLY;
    end else if (!acq_on) begin
      scan_cnt <= start_dly; // (R10)
    end else if (int_scan_fire) begin
      scan_cnt <= scan_div; // (R4)
    end else if (scan_src == SRC_DIVIDED && !paused && scan_tb_tick) begin
      scan_cnt <= scan_cnt - DIV_W'(1); // (R9)
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      remain <= '0;
    end else if (state == ST_IDLE && start_req) begin
      remain <= samples; // (R23)
    end else if (accept_scan && remain != '0) begin
      remain <= remain - CNT_W'(1); // (R23)
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      conv_left <= '0;
      conv_cnt  <= RST_CONV_DLY;
      chan_idx  <= '0;
    end else if (!acq_on) begin
      conv_left <= '0;
      conv_cnt  <= conv_dly;
    end else if (accept_scan) begin
      conv_left <= channels; // (R1) (R25)
      conv_cnt  <= conv_dly; // (R19)
      chan_idx  <= '0;
    end else if (accept_conv) begin
      conv_left <= conv_left - CH_W'(1); // (R14)
      conv_cnt  <= (conv_left == CH_W'(1)) ? conv_dly : conv_div; // (R17)
      chan_idx  <= chan_idx + CH_W'(1);
    end else if (conv_src == SRC_DIVIDED && conv_left != '0 && conv_tb_tick) begin
      conv_cnt <= conv_cnt - DIV_W'(1); // (R17)
    end
  end
  // Set wins over a clear in the same cycle
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      overrun <= 1'b0;
    end else if (accept_scan && conv_left != '0) begin
      overrun <= 1'b1; // (R22) (R26)
    end else if (wb_wr && WB_ADR_I == OFS_STATUS && WB_SEL_I[0] && WB_DAT_I[STS_OVERRUN]) begin
      overrun <= 1'b0; // (R26)
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      SCAN_START      <= 1'b0;
      CONVERT_START   <= 1'b0;
      CONVERT_CHANNEL <= '0;
      ACQ_ACTIVE      <= 1'b0;
      SCAN_OVERRUN    <= 1'b0;
    end else begin
      SCAN_START    <= accept_scan;
      CONVERT_START <= accept_conv; // (R14)
      if (accept_conv) CONVERT_CHANNEL <= 8'(chan_idx);
      ACQ_ACTIVE    <= acq_on;
      SCAN_OVERRUN  <= overrun | (accept_scan && conv_left != '0);
    end
  end
  // Terminal routing: scan pulse is active high, conversion pulse active low
  always_comb begin
    for (int i = 0; i < ROUTE_W; i++) begin
      route_val[i] = route_sel[i] ? ~accept_conv : accept_scan; // (R5) (R18)
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      FUNC_LINES_OUT  <= '0;
      FUNC_LINES_OE_N <= '1; // (R6)
      TRIG_BUS_OUT    <= '0;
      TRIG_BUS_OE_N   <= '1;
      STAR_OUT        <= 1'b0;
      STAR_OE_N       <= 1'b1;
    end else begin
      FUNC_LINES_OUT  <= route_val[15:0] & route_en[15:0];
      FUNC_LINES_OE_N <= ~route_en[15:0]; // (R6)
      TRIG_BUS_OUT    <= route_val[23:16] & route_en[23:16];
      TRIG_BUS_OE_N   <= ~route_en[23:16];
      STAR_OUT        <= route_val[24] & route_en[24];
      STAR_OE_N       <= ~route_en[24];
    end
  end

endmodule
`default_nettype wire

// >>> rtl/acq_timing_pkg.sv
// Summary of operation
// (R1) Each accepted scan converts every listed channel
// (R2) Scan pulse edge is software selectable
// (R3) Scan pulse source is software selectable
// (R4) Divided timebase source uses a programmable divider
// (R5) Routed scan pulse drives active high
// (R6) Function lines stay inputs until enabled
// (R7) Scan pulses ignored outside an acquisition
// (R8) Scan pulses ignored while pause is active
// (R9) Start trigger starts divider; completion stops it
// (R10) Start to first scan delay, default four
// (R11) External scan source must respect conversion timing
// (R12) Scan timebase source is software selectable
// (R13) Timebase edge selectable except fast internal ones
// (R14) Each accepted conversion pulse converts one channel
// (R15) Conversion pulse edge is software selectable
// (R16) Conversion pulse source is software selectable
// (R17) Conversion divider counts down, fires, reloads
// (R18) Routed conversion pulse drives active low
// (R19) Scan to first conversion delay, default three
// (R20) All pulses ignored before a start trigger
// (R21) Conversions only between scan and channel count
// (R22) Early scan pulse raises scan overrun
// (R23) Sample counter decrements on each accepted scan; the code holds it at zero once it gets there in continuous mode
// (R24) Conversion timebase is scan timebase or 100 MHz
// (R25) Conversions per scan equal configured channel count
// (R26) Scan overrun is sticky until software clears
package acq_timing_pkg;
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CMD       = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_SOURCE    = 8'h0c;
  localparam logic [7:0] OFS_SCAN_DIV  = 8'h10;
  localparam logic [7:0] OFS_CONV_DIV  = 8'h14;
  localparam logic [7:0] OFS_START_DLY = 8'h18;
  localparam logic [7:0] OFS_CONV_DLY  = 8'h1c;
  localparam logic [7:0] OFS_SAMPLES   = 8'h20;
  localparam logic [7:0] OFS_CHANNELS  = 8'h24;
  localparam logic [7:0] OFS_ROUTE_EN  = 8'h28;
  localparam logic [7:0] OFS_ROUTE_SEL = 8'h2c;
  localparam logic [7:0] OFS_REMAIN    = 8'h30;
  // Control fields
  localparam int CTRL_CONTINUOUS = 0;
  localparam int CTRL_SCAN_FALL  = 1;
  localparam int CTRL_CONV_FALL  = 2;
  localparam int CTRL_TB_FALL    = 3;
  localparam int CTRL_PAUSE_LOW  = 4;
  localparam int CTRL_CONV_TB100 = 5;
  localparam int CTRL_W          = 6;
  // Command and status fields
  localparam int CMD_START   = 0;
  localparam int CMD_STOP    = 1;
  localparam int CMD_SW_SCAN = 2;
  localparam int STS_ACTIVE  = 0;
  localparam int STS_OVERRUN = 1;
  localparam int STS_IN_SCAN = 2;
  // Source field positions and codes; codes below 32 pick a line
  localparam int SRC_SCAN_POS = 0;
  localparam int SRC_CONV_POS = 8;
  localparam int SRC_TB_POS   = 16;
  localparam logic [5:0] SRC_DIVIDED  = 6'h20;
  localparam logic [5:0] SRC_SOFTWARE = 6'h21;
  localparam logic [5:0] TB_100M      = 6'h20;
  localparam logic [5:0] TB_20M       = 6'h21;
  localparam logic [5:0] TB_100K      = 6'h22;
  localparam logic [5:0] TB_CLK10     = 6'h23;
  // Reset values
  localparam logic [15:0] RST_START_DLY = 16'h0004;
  localparam logic [15:0] RST_CONV_DLY  = 16'h0003;
  localparam logic [15:0] RST_DIV       = 16'h0002;
  localparam logic [7:0]  RST_CHANNELS  = 8'h01;
  localparam logic [5:0]  RST_SCAN_SRC  = SRC_DIVIDED;
  localparam logic [5:0]  RST_CONV_SRC  = SRC_DIVIDED;
  localparam logic [5:0]  RST_TB_SRC    = TB_100M;
  localparam int ROUTE_W = 25;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN} acq_state_t;
endpackage

// >>> tb/acq_front_partner.sv
`timescale 1ns/1ps
`default_nettype none
module acq_front_partner (
  input  wire logic        clock,
  input  wire logic        resetn,
  output logic      [31:0] lines,
  output logic      [3:0]  timebases
);
  logic [7:0]  div;
  logic [29:0] noise;
  logic [1:0]  pulse_lines = 2'b00;
  // Unselected lines toggle at random so a wrong source pick shows up
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div <= 8'h00;
      noise <= 30'h0;
    end else begin
      div <= div + 8'h01;
      noise <= 30'($urandom);
    end
  end
  assign timebases = {div[3], div[4], div[2], div[1]};
  assign lines = {noise, pulse_lines};
  // Pulses are spaced wide enough for the configured conversions
  task automatic pulse(input int idx);
    @(posedge clock);
    pulse_lines[idx] <= 1'b1;
    repeat (2) @(posedge clock);
    pulse_lines[idx] <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// >>> tb/acq_timing_checker.sv
`timescale 1ns/1ps
`default_nettype none
module acq_timing_checker
  import acq_timing_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RESETN,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic        WB_ACK_O,
  input wire logic [15:0] FUNC_LINES_OUT,
  input wire logic [15:0] FUNC_LINES_OE_N,
  input wire logic [7:0]  TRIG_BUS_OE_N,
  input wire logic        STAR_OE_N,
  input wire logic        CONVERT_START,
  input wire logic        SCAN_START,
  input wire logic        ACQ_ACTIVE,
  input wire logic        SCAN_OVERRUN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  property p_ack_once;
    (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack timing wrong");
  property p_ack_cause;
    WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_oe_reset;
    $rose(RESETN) |-> (FUNC_LINES_OE_N == 16'hffff) && (TRIG_BUS_OE_N == 8'hff) && STAR_OE_N;
  endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("lines not inputs after reset");
  property p_out_quiet;
    (FUNC_LINES_OUT & FUNC_LINES_OE_N) == 16'h0000;
  endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("undriven line shows data");
  property p_scan_active;
    SCAN_START |-> ACQ_ACTIVE || $past(ACQ_ACTIVE);
  endproperty
  a_scan_active: assert property (p_scan_active) else $error("scan outside run");
  property p_conv_active;
    CONVERT_START |-> ACQ_ACTIVE || $past(ACQ_ACTIVE);
  endproperty
  a_conv_active: assert property (p_conv_active) else $error("conversion outside run");
  property p_no_both;
    !(SCAN_START && CONVERT_START);
  endproperty
  a_no_both: assert property (p_no_both) else $error("scan and conversion together");
  property p_ovr_cause;
    $rose(SCAN_OVERRUN) |-> SCAN_START;
  endproperty
  a_ovr_cause: assert property (p_ovr_cause) else $error("overrun without scan");
  property p_ovr_sticky;
    $fell(SCAN_OVERRUN) |-> $past(WB_ACK_O && WB_WE_I && WB_SEL_I[0]
      && WB_ADR_I == OFS_STATUS && WB_DAT_I[STS_OVERRUN], 2);
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun cleared alone");
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import acq_timing_pkg::*;
  logic        clock, resetn, cyc, stb, we;
  logic        pause, start, ack, ovr, active, conv, scan, s_out, s_oe;
  logic [7:0]  adr, chan, t_out, t_oe;
  logic [3:0]  sel, tbs;
  logic [31:0] dat_w, dat_r, rd, lines;
  logic [15:0] f_out, f_oe, f_in;
  int          n_fail, checks_done, cycles, scans, convs, exp_ch, ch, n;
  int          t_start, t_scan, scan_gap, conv_gap, hi_scan, lo_conv;
  logic [5:0]  codes [4] = '{TB_100M, TB_20M, TB_100K, TB_CLK10};
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Routed lines win over the partner where the design drives them
  assign f_in = (f_out & ~f_oe) | (lines[15:0] & f_oe);
  acq_front_partner part (.clock(clock), .resetn(resetn), .lines(lines), .timebases(tbs));
  acq_sample_convert_timing dut (.CLOCK(clock), .RESETN(resetn), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r),
    .WB_ACK_O(ack), .TIMEBASE_100M(tbs[0]), .TIMEBASE_20M(tbs[1]), .TIMEBASE_100K(tbs[2]),
    .BACKPLANE_10MHZ_CLOCK(tbs[3]), .FUNC_LINES_IN(f_in), .TRIG_BUS_IN(lines[23:16]),
    .STAR_IN(lines[24]), .DIFF_STAR_IN(lines[26:25]), .ANALOG_COMPARE_EVENT(lines[27]),
    .COUNTER_OUTPUT(lines[28]), .CHANGE_DETECT_EVENT(lines[29]),
    .OTHER_SCAN_PULSE(lines[31:30]), .START_TRIGGER(start), .PAUSE_TRIGGER(pause),
    .FUNC_LINES_OUT(f_out), .FUNC_LINES_OE_N(f_oe), .TRIG_BUS_OUT(t_out), .TRIG_BUS_OE_N(t_oe),
    .STAR_OUT(s_out), .STAR_OE_N(s_oe), .CONVERT_START(conv), .CONVERT_CHANNEL(chan),
    .SCAN_START(scan), .ACQ_ACTIVE(active), .SCAN_OVERRUN(ovr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d; sel <= 4'hf;
    k = 0;
    do begin @(posedge clock); k++; end while (ack !== 1'b1 && k < 64);
    if (k >= 64) begin n_fail++; finish_test; end
    rd = dat_r;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // Reference model: each scan restarts the channel walk from zero
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin n_fail++; finish_test; end
    if (resetn && scan === 1'b1) begin
      scans++;
      if (scans == 1) scan_gap = cycles - t_start;
      t_scan = cycles;
      exp_ch = 0;
    end
    if (resetn && conv === 1'b1) begin
      chk(chan, 32'(exp_ch), "channel order");
      chk(exp_ch < ch, 1, "surplus conversion");
      if (exp_ch == 0) conv_gap = cycles - t_scan;
      exp_ch++;
      convs++;
    end
    if (f_out[4] === 1'b1) hi_scan++;
    if (f_out[5] === 1'b0 && f_oe[5] === 1'b0) lo_conv++;
  end
  initial begin
    void'($urandom(32'h8271));
    {resetn, cyc, stb, we, pause, start, adr, sel, dat_w} <= '0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    chk(f_oe, 16'hffff, "lines not inputs");
    wb(0, OFS_START_DLY, 0); chk(rd, 32'h4, "start delay reset");
    wb(0, OFS_CONV_DLY, 0); chk(rd, 32'h3, "conversion delay reset");
    wb(0, OFS_CHANNELS, 0); chk(rd, 32'h1, "channel count reset");
    wb(0, 8'hfc, 0); chk(rd, 32'h0, "unmapped read");
    for (int e = 0; e < 2; e++) begin
      ch = $urandom_range(4, 1);
      wb(1, OFS_CTRL, e ? 32'h6 : 32'h0);
      wb(1, OFS_SOURCE, 32'h0020_0100);
      wb(1, OFS_CHANNELS, ch);
      wb(1, OFS_SAMPLES, 32'h2);
      scans = 0; convs = 0;
      part.pulse(0); part.pulse(1);
      chk(scans + convs, 0, "pulse before start");
      wb(1, OFS_CMD, 32'h1);
      part.pulse(1);
      for (int s = 0; s < 2; s++) begin
        part.pulse(0);
        repeat (ch + 1) part.pulse(1);
      end
      repeat (8) @(posedge clock);
      chk(scans, 2, "scan count");
      chk(convs, 2 * ch, "conversion count");
      chk(active, 0, "finite run still active");
      wb(0, OFS_REMAIN, 0); chk(rd, 32'h0, "remaining samples");
      part.pulse(0); repeat (4) @(posedge clock);
      chk(scans, 2, "scan after end");
    end
    // Pause gating, then a scan that arrives before its conversions are done
    wb(1, OFS_CTRL, 0); wb(1, OFS_CHANNELS, 2); wb(1, OFS_SAMPLES, 3);
    ch = 2; scans = 0; convs = 0;
    wb(1, OFS_CMD, 32'h1);
    pause <= 1'b1; repeat (3) @(posedge clock);
    part.pulse(0);
    chk(scans, 0, "scan while paused");
    pause <= 1'b0; repeat (3) @(posedge clock);
    part.pulse(0); part.pulse(1); part.pulse(0);
    chk(ovr, 1, "overrun not raised");
    repeat (20) @(posedge clock);
    wb(0, OFS_STATUS, 0); chk(rd[STS_OVERRUN], 1, "overrun not sticky");
    wb(1, OFS_STATUS, 32'h2); wb(0, OFS_STATUS, 0);
    chk(rd[STS_OVERRUN], 0, "overrun not cleared");
    wb(1, OFS_CMD, 32'h2); repeat (3) @(posedge clock);
    chk(active, 0, "stop command");
    // Routing, then divided timebases from each internal source
    wb(1, OFS_ROUTE_EN, 32'h30); wb(1, OFS_ROUTE_SEL, 32'h20);
    repeat (2) @(posedge clock);
    chk(f_oe, 16'hffcf, "route enable");
    chk(32'({t_oe, s_oe, t_out, s_out}), 32'h0003_fe00, "unrouted terminals");
    chk({f_out[5], f_out[4]}, 2'b10, "idle routed levels");
    wb(1, OFS_SCAN_DIV, 40); wb(1, OFS_CONV_DIV, 2); wb(1, OFS_START_DLY, 6);
    wb(1, OFS_CONV_DLY, 5);
    for (int c = 0; c < 4; c++) begin
      wb(1, OFS_CTRL, codes[c] == TB_100K ? 32'h8 : 32'h0);
      wb(1, OFS_SOURCE, {10'h0, codes[c], 16'h2020});
      scans = 0; convs = 0; hi_scan = 0; lo_conv = 0;
      @(posedge clock);
      start <= 1'b1; t_start = cycles;
      repeat (4) @(posedge clock);
      start <= 1'b0;
      n = 0;
      do begin @(posedge clock); n++; end while (active !== 1'b0 && n < 12000);
      chk(scans, 3, "divided scan count");
      chk(convs, 6, "divided conversion count");
      if (c == 0) begin
        chk(scan_gap >= 17 && scan_gap <= 32, 1, "start to scan delay");
        chk(conv_gap >= 16 && conv_gap <= 22, 1, "scan to conversion delay");
        chk(hi_scan > 0 && lo_conv > 0, 1, "routed pulses");
      end
    end
    finish_test;
  end
endmodule
bind acq_sample_convert_timing acq_timing_checker u_chk (.CLOCK(CLOCK), .RESETN(RESETN),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
  .FUNC_LINES_OUT(FUNC_LINES_OUT), .FUNC_LINES_OE_N(FUNC_LINES_OE_N),
  .TRIG_BUS_OE_N(TRIG_BUS_OE_N), .STAR_OE_N(STAR_OE_N), .CONVERT_START(CONVERT_START),
  .SCAN_START(SCAN_START), .ACQ_ACTIVE(ACQ_ACTIVE), .SCAN_OVERRUN(SCAN_OVERRUN));
`default_nettype wire
